// File: rtl/status_indicator_duplex_supervisor.sv

`timescale 1ns/100ps
`default_nettype none

module status_indicator_duplex_supervisor
    import indicator_pkg::*;
#(
    parameter int unsigned VERIFY_CYCLES = VERIFY_MAX_CYC
) (
    // Clock, reset, enable
    input  wire logic            clk_i,
    input  wire logic            srst_i,
    input  wire logic            ce_i,
    // Processor health
    input  wire logic [NCPU-1:0] cpu_ok_i,
    input  wire logic [NCPU-1:0] cpu_fatal_i,
    input  wire logic [NCPU-1:0] cpu_nonfatal_i,
    input  wire logic [NCPU-1:0] output_off_bit_i,
    input  wire logic [NCPU-1:0] cpu_fault_i,
    input  wire logic [NCPU-1:0] mem_fault_i,
    // Supervisor status
    input  wire logic            sup_ok_i,
    input  wire logic            sup_bus_fault_i,
    input  wire logic            duplex_start_i,
    input  wire logic            verify_done_i,
    input  wire logic            verify_mismatch_i,
    input  wire logic            exec_start_fail_i,
    input  wire logic            program_mode_i,
    // Processor lamps and controls
    output logic [NCPU-1:0]      run_lamp_o,
    output logic [NCPU-1:0]      fatal_lamp_o,
    output logic [NCPU-1:0]      alarm_lamp_o,
    output logic [NCPU-1:0]      output_inhibit_lamp_o,
    output logic [NCPU-1:0]      cpu_halt_o,
    output logic [NCPU-1:0]      outputs_off_o,
    // Supervisor lamps and controls
    output logic                 sup_run_lamp_o,
    output logic                 bus_error_lamp_o,
    output logic                 verify_mismatch_lamp_o,
    output logic [NCPU-1:0]      active_cpu_lamp_o,
    output logic                 cpu_run_lamp_o,
    output logic                 verification_pending_lamp_o,
    output logic                 program_lamp_o,
    output logic                 processor_error_lamp_o,
    output logic                 memory_error_lamp_o,
    output logic                 simplex_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam logic [VCNT_W-1:0] VLIM = VCNT_W'(VERIFY_CYCLES - 1);
    logic                proc_err_q, proc_err_d;
    logic                mem_err_q, mem_err_d;
    logic                stop_all;
    logic [NCPU-1:0]     run_lamp;
    logic [NCPU-1:0]     halted;
    logic                bus_err_q, bus_err_d;
    logic                mism_q, mism_d;
    logic                sup_run_q, sup_run_d;
    logic                cpu_run_q, cpu_run_d;
    logic                prog_q, prog_d;
    logic                simplex_q, simplex_d;
    active_state_e       act_q, act_d;
    start_state_e        st_q, st_d;
    logic [VCNT_W-1:0]   vcnt_q, vcnt_d;
    logic                pend_q, pend_d;

    // ----------------------------------------------------------------
    // Processor and memory errors
    // ----------------------------------------------------------------
    // Both errors are held until reset and are registered with the
    // supervisor lamps. The next value is used so that the stop reaches
    // the processors in the same edge that lights the lamp.
    assign stop_all = proc_err_d | mem_err_d;

    // ----------------------------------------------------------------
    // Per-processor indicators
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NCPU; i++) begin : g_cpu
        cpu_status_if cs ();
        assign cs.ok       = cpu_ok_i[i];
        assign cs.fatal    = cpu_fatal_i[i];
        assign cs.nonfatal = cpu_nonfatal_i[i];
        assign cs.out_off  = output_off_bit_i[i];
        assign cs.stop     = stop_all;
        cpu_indicator u_cpu (
            .clk_i  (clk_i),
            .srst_i (srst_i),
            .ce_i   (ce_i),
            .u      (cs.unit)
        );
        assign run_lamp[i]              = cs.run_lamp;
        assign halted[i]                = cs.halted;
        assign run_lamp_o[i]            = cs.run_lamp;
        assign fatal_lamp_o[i]          = cs.err_lamp;
        assign alarm_lamp_o[i]          = cs.alarm_lamp;
        assign output_inhibit_lamp_o[i] = cs.inhb_lamp;
        assign cpu_halt_o[i]            = cs.halted;
        assign outputs_off_o[i]         = cs.outs_off;
    end

    // ----------------------------------------------------------------
    // Supervisor lamps
    // ----------------------------------------------------------------
    // Bus fault and program mismatch are held: simplex operation stays
    // in force until reset restores redundant operation.
    always_comb begin
        proc_err_d = proc_err_q;
        mem_err_d  = mem_err_q;
        bus_err_d = bus_err_q;
        mism_d    = mism_q;
        sup_run_d = sup_run_q;
        cpu_run_d = cpu_run_q;
        prog_d    = prog_q;
        simplex_d = simplex_q;
        if (ce_i) begin
            proc_err_d = proc_err_q | (|cpu_fault_i);
            mem_err_d  = mem_err_q | (|mem_fault_i);
            bus_err_d = bus_err_q | sup_bus_fault_i;
            mism_d    = mism_q | verify_mismatch_i;
            sup_run_d = sup_ok_i & ~bus_err_d & ~mism_d;
            cpu_run_d = (&run_lamp) & ~stop_all;
            prog_d    = program_mode_i;
            simplex_d = bus_err_d | mism_d | (|halted);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            proc_err_q <= LAMP_RST;
            mem_err_q  <= LAMP_RST;
            bus_err_q <= LAMP_RST;
            mism_q    <= LAMP_RST;
            sup_run_q <= LAMP_RST;
            cpu_run_q <= LAMP_RST;
            prog_q    <= LAMP_RST;
            simplex_q <= LAMP_RST;
        end else begin
            proc_err_q <= proc_err_d;
            mem_err_q  <= mem_err_d;
            bus_err_q <= bus_err_d;
            mism_q    <= mism_d;
            sup_run_q <= sup_run_d;
            cpu_run_q <= cpu_run_d;
            prog_q    <= prog_d;
            simplex_q <= simplex_d;
        end
    end

    // ----------------------------------------------------------------
    // Active processor
    // ----------------------------------------------------------------
    // Control moves only to a processor that is itself still running,
    // so a double failure leaves the indication where it was.
    always_comb begin
        act_d = act_q;
        if (ce_i) begin
            unique case (act_q)
                ACT_A: begin
                    if (halted[0] && !halted[1]) begin
                        act_d = ACT_B;
                    end
                end
                ACT_B: begin
                    if (halted[1] && !halted[0]) begin
                        act_d = ACT_A;
                    end
                end
                default: begin
                    act_d = ACT_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            act_q <= ACT_RST;
        end else begin
            act_q <= act_d;
        end
    end

    // ----------------------------------------------------------------
    // Start-up verification
    // ----------------------------------------------------------------
    // A verification that never reports is caught by the time limit and
    // treated as a failed start, so the lamp cannot hang in between.
    always_comb begin
        st_d   = st_q;
        vcnt_d = vcnt_q;
        pend_d = pend_q;
        if (ce_i) begin
            unique case (st_q)
                ST_IDLE, ST_RUNNING, ST_STUCK: begin
                    if (duplex_start_i) begin
                        st_d   = ST_VERIFY;
                        vcnt_d = VCNT_RST;
                    end
                end
                ST_VERIFY: begin
                    vcnt_d = vcnt_q + 1'b1;
                    if (exec_start_fail_i || sup_bus_fault_i) begin
                        st_d = ST_STUCK;
                    end else if (verify_done_i) begin
                        st_d = ST_RUNNING;
                    end else if (vcnt_q == VLIM) begin
                        st_d = ST_STUCK;
                    end
                end
                default: begin
                    st_d = ST_RST;
                end
            endcase
            pend_d = (st_d == ST_VERIFY) || (st_d == ST_STUCK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q   <= ST_RST;
            vcnt_q <= VCNT_RST;
            pend_q <= LAMP_RST;
        end else begin
            st_q   <= st_d;
            vcnt_q <= vcnt_d;
            pend_q <= pend_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sup_run_lamp_o              = sup_run_q;
    assign bus_error_lamp_o            = bus_err_q;
    assign verify_mismatch_lamp_o      = mism_q;
    assign active_cpu_lamp_o           = act_q;
    assign cpu_run_lamp_o              = cpu_run_q;
    assign verification_pending_lamp_o = pend_q;
    assign program_lamp_o              = prog_q;
    assign processor_error_lamp_o      = proc_err_q;
    assign memory_error_lamp_o         = mem_err_q;
    assign simplex_o                   = simplex_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_start;
        ce_i && duplex_start_i && (st_q != ST_VERIFY);
    endsequence

    sequence s_start_fail;
        ce_i && (st_q == ST_VERIFY) && exec_start_fail_i;
    endsequence

    property p_sup_run;
        sup_run_q && $past(ce_i) |-> $past(sup_ok_i) && !bus_err_q && !mism_q;
    endproperty
    a_sup_run: assert property (p_sup_run)
        else $error("Supervisor run lamp lit while not normal.");

    property p_bus_fault;
        (ce_i && sup_bus_fault_i) |=> (bus_err_q && !sup_run_q && simplex_q);
    endproperty
    a_bus_fault: assert property (p_bus_fault)
        else $error("Bus fault not shown or simplex not entered.");

    property p_mismatch;
        (ce_i && verify_mismatch_i) |=> (mism_q && !sup_run_q && simplex_q);
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("Program mismatch not shown or simplex not entered.");

    property p_active_onehot;
        $onehot(active_cpu_lamp_o);
    endproperty
    a_active_onehot: assert property (p_active_onehot)
        else $error("Active processor indication not one-hot.");

    property p_cpu_run;
        (cpu_run_q && $past(ce_i))
            |-> ($past(&run_lamp) && !proc_err_q && !mem_err_q);
    endproperty
    a_cpu_run: assert property (p_cpu_run)
        else $error("Processor-run lamp lit without both run lamps.");

    property p_pending;
        s_start |=> pend_q && (st_q == ST_VERIFY);
    endproperty
    a_pending: assert property (p_pending)
        else $error("Pending lamp not lit at start of verification.");

    property p_stuck;
        s_start_fail |=> (st_q == ST_STUCK) ##1 (pend_q || duplex_start_i);
    endproperty
    a_stuck: assert property (p_stuck)
        else $error("Pending lamp went out after a failed start.");

    property p_program;
        ce_i |=> (prog_q == $past(program_mode_i));
    endproperty
    a_program: assert property (p_program)
        else $error("Program-mode lamp does not follow the mode.");

    property p_proc_err;
        (ce_i && (|cpu_fault_i))
            |=> (proc_err_q && (&halted) && !cpu_run_q && !(|run_lamp));
    endproperty
    a_proc_err: assert property (p_proc_err)
        else $error("Processor error did not stop the processors.");

    property p_mem_err;
        (ce_i && (|mem_fault_i))
            |=> (mem_err_q && (&halted) && !cpu_run_q && !(|run_lamp));
    endproperty
    a_mem_err: assert property (p_mem_err)
        else $error("Memory error did not stop the processors.");

endmodule

`default_nettype wire

// File: rtl/indicator_pkg.sv
package indicator_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned VERIFY_MAX_S    = 20;
    localparam int unsigned VERIFY_MAX_CYC  = VERIFY_MAX_S * CLK_HZ;
    localparam int unsigned VCNT_W          = 29;

    // ----------------------------------------------------------------
    // Structure and reset values
    // ----------------------------------------------------------------
    localparam int unsigned NCPU            = 2;
    localparam int unsigned OUTPUT_OFF_BIT  = 25215;
    localparam logic        LAMP_RST        = 1'b0;
    localparam logic [VCNT_W-1:0] VCNT_RST  = '0;

    // Start-up supervision of redundant operation.
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_VERIFY  = 4'b0010,
        ST_RUNNING = 4'b0100,
        ST_STUCK   = 4'b1000
    } start_state_e;

    // Which processor holds control.
    typedef enum logic [1:0] {
        ACT_A = 2'b01,
        ACT_B = 2'b10
    } active_state_e;

    localparam active_state_e ACT_RST = ACT_A;
    localparam start_state_e  ST_RST  = ST_IDLE;

endpackage

// File: rtl/cpu_status_if.sv
`timescale 1ns/100ps
`default_nettype none

interface cpu_status_if;
    logic ok;
    logic fatal;
    logic nonfatal;
    logic out_off;
    logic stop;
    logic run_lamp;
    logic err_lamp;
    logic alarm_lamp;
    logic inhb_lamp;
    logic halted;
    logic outs_off;

    modport unit (
        input  ok, fatal, nonfatal, out_off, stop,
        output run_lamp, err_lamp, alarm_lamp, inhb_lamp, halted, outs_off
    );

    modport sup (
        output ok, fatal, nonfatal, out_off, stop,
        input  run_lamp, err_lamp, alarm_lamp, inhb_lamp, halted, outs_off
    );
endinterface

`default_nettype wire

// File: rtl/cpu_indicator.sv
`timescale 1ns/100ps
`default_nettype none

module cpu_indicator
    import indicator_pkg::*;
(
    // Clock, reset, enable
    input  wire logic    clk_i,
    input  wire logic    srst_i,
    input  wire logic    ce_i,
    // Processor status and lamps
    cpu_status_if.unit   u
);

    // ----------------------------------------------------------------
    // Processor lamps
    // ----------------------------------------------------------------
    logic run_q, run_d;
    logic err_q, err_d;
    logic alarm_q, alarm_d;
    logic inhb_q, inhb_d;
    logic halt_q, halt_d;
    logic off_q, off_d;

    // A fatal error is held until reset, as the processor stays stopped.
    always_comb begin
        run_d   = run_q;
        err_d   = err_q;
        alarm_d = alarm_q;
        inhb_d  = inhb_q;
        halt_d  = halt_q;
        off_d   = off_q;
        if (ce_i) begin
            err_d   = err_q | u.fatal;
            halt_d  = err_d | u.stop;
            run_d   = u.ok & ~halt_d;
            alarm_d = u.nonfatal;
            inhb_d  = u.out_off;
            off_d   = err_d | u.out_off;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run_q   <= LAMP_RST;
            err_q   <= LAMP_RST;
            alarm_q <= LAMP_RST;
            inhb_q  <= LAMP_RST;
            halt_q  <= LAMP_RST;
            off_q   <= LAMP_RST;
        end else begin
            run_q   <= run_d;
            err_q   <= err_d;
            alarm_q <= alarm_d;
            inhb_q  <= inhb_d;
            halt_q  <= halt_d;
            off_q   <= off_d;
        end
    end

    assign u.run_lamp   = run_q;
    assign u.err_lamp   = err_q;
    assign u.alarm_lamp = alarm_q;
    assign u.inhb_lamp  = inhb_q;
    assign u.halted     = halt_q;
    assign u.outs_off   = off_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_fatal_stop;
        @(posedge clk_i) disable iff (srst_i)
        (ce_i && u.fatal) |=> (err_q && !run_q && halt_q && off_q);
    endproperty
    a_fatal_stop: assert property (p_fatal_stop)
        else $error("Fatal error did not stop the processor.");

    property p_alarm_runs;
        @(posedge clk_i) disable iff (srst_i)
        (ce_i && u.nonfatal && u.ok && !u.fatal && !u.stop && !err_q)
            |=> (alarm_q && run_q && !halt_q);
    endproperty
    a_alarm_runs: assert property (p_alarm_runs)
        else $error("Non-fatal error changed normal operation.");

    property p_inhibit;
        @(posedge clk_i) disable iff (srst_i)
        (ce_i && u.out_off) |=> (inhb_q && off_q);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("Output inhibit not shown or outputs left on.");

    property p_run_normal;
        @(posedge clk_i) disable iff (srst_i)
        (run_q && $past(ce_i)) |-> ($past(u.ok) && !halt_q);
    endproperty
    a_run_normal: assert property (p_run_normal)
        else $error("Run lamp lit while processor not normal.");

endmodule

`default_nettype wire

// File: dv/lamp_panel.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Operator view of the front panel
// ----------------------------------------------------------------
// An operator may glance away, so every lamp lit once is remembered.
module lamp_panel (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Lamps on the panel
    input  wire logic [11:0] lamps_i,
    // Lamps lit at least once since reset
    output logic      [11:0] seen_o
);
    logic [11:0] seen_d;
    logic [11:0] seen_q;

    always_comb begin
        seen_d = srst_i ? 12'h000 : (seen_q | lamps_i);
    end

    always_ff @(posedge clk_i) begin
        seen_q <= seen_d;
    end

    assign seen_o = seen_q;
endmodule

`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import indicator_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int unsigned VCYC = 16;
    logic        clk_i = 1'b0;
    logic        srst_i;
    logic        ce_i;
    logic        prst;
    logic [1:0]  ok, fat, nfat, offb, cflt, mflt;
    logic        sup_ok, bus_f, dstart, vdone, vmis, sfail, pmode;
    logic [1:0]  run_l, fat_l, alm_l, inh_l, halt, offo, act;
    logic        sup_run, bus_l, mis_l, cpu_run, pend, prog_l;
    logic        perr, merr, simplex;
    logic [11:0] seen;
    int          errors = 0;
    int          checks = 0;

    always #20 clk_i = ~clk_i;

    status_indicator_duplex_supervisor #(.VERIFY_CYCLES(VCYC))
    status_indicator_duplex_supervisor_inst (
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .cpu_ok_i(ok),
        .cpu_fatal_i(fat), .cpu_nonfatal_i(nfat), .output_off_bit_i(offb),
        .cpu_fault_i(cflt), .mem_fault_i(mflt), .sup_ok_i(sup_ok),
        .sup_bus_fault_i(bus_f), .duplex_start_i(dstart),
        .verify_done_i(vdone), .verify_mismatch_i(vmis),
        .exec_start_fail_i(sfail), .program_mode_i(pmode),
        .run_lamp_o(run_l), .fatal_lamp_o(fat_l), .alarm_lamp_o(alm_l),
        .output_inhibit_lamp_o(inh_l), .cpu_halt_o(halt),
        .outputs_off_o(offo), .sup_run_lamp_o(sup_run),
        .bus_error_lamp_o(bus_l), .verify_mismatch_lamp_o(mis_l),
        .active_cpu_lamp_o(act), .cpu_run_lamp_o(cpu_run),
        .verification_pending_lamp_o(pend), .program_lamp_o(prog_l),
        .processor_error_lamp_o(perr), .memory_error_lamp_o(merr),
        .simplex_o(simplex));

    lamp_panel lamp_panel_inst (
        .clk_i(clk_i), .srst_i(prst),
        .lamps_i({pend, prog_l, perr, merr, bus_l, mis_l, |fat_l, |alm_l,
                  |inh_l, cpu_run, sup_run, |run_l}),
        .seen_o(seen));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic cmp(input string what, input logic [1:0] exp,
                       input logic [1:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Sticky faults clear only by reset, so each fault case starts clean.
    task automatic rst;
        {fat, nfat, offb, cflt, mflt} = '0;
        {bus_f, dstart, vdone, vmis, sfail, pmode} = '0;
        srst_i = 1'b1;
        step(2);
        srst_i = 1'b0;
        step(1);
    endtask

    task automatic conclude;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        step(5000);
        errors++;
        conclude();
    end

    initial begin
        {fat, nfat, offb, cflt, mflt, ok} = '0;
        {sup_ok, bus_f, dstart, vdone, vmis, sfail, pmode} = '0;
        srst_i = 1'b1;
        prst = 1'b1;
        ce_i = 1'b1;
        step(16);
        cmp("act_rst", 2'b01, act);
        cmp("lamps_rst", 2'b00, {sup_run | pend | cpu_run, |run_l});
        srst_i = 1'b0;
        prst = 1'b0;
        ok = 2'b11;
        sup_ok = 1'b1;
        step(1);
        cmp("run", 2'b11, run_l);
        cmp("sup_run", 2'b01, {1'b0, sup_run});
        step(1);
        cmp("cpu_run", 2'b01, {1'b0, cpu_run});
        ok = 2'b10;
        step(1);
        cmp("run_one", 2'b10, run_l);
        ok = 2'b11;
        ce_i = 1'b0;
        pmode = 1'b1;
        step(1);
        cmp("prog_frozen", 2'b00, {1'b0, prog_l});
        ce_i = 1'b1;
        step(1);
        cmp("prog", 2'b01, {1'b0, prog_l});
        pmode = 1'b0;
        nfat = 2'b10;
        step(1);
        cmp("alarm", 2'b10, alm_l);
        cmp("alarm_run", 2'b11, run_l | halt | offo);
        nfat = 2'b00;
        offb = 2'b01;
        step(1);
        cmp("inhibit", 2'b01, inh_l);
        cmp("outs_off", 2'b01, offo);
        offb = 2'b00;
        step(1);
        cmp("inhibit_end", 2'b00, inh_l | offo);
        dstart = 1'b1;
        step(1);
        dstart = 1'b0;
        cmp("pend", 2'b01, {1'b0, pend});
        step(3);
        vdone = 1'b1;
        step(1);
        vdone = 1'b0;
        cmp("pend_done", 2'b00, {1'b0, pend});
        dstart = 1'b1;
        step(1);
        dstart = 1'b0;
        sfail = 1'b1;
        step(1);
        sfail = 1'b0;
        step(VCYC + 4);
        cmp("pend_fail", 2'b01, {1'b0, pend});
        dstart = 1'b1;
        step(1);
        dstart = 1'b0;
        step(VCYC + 4);
        vdone = 1'b1;
        step(1);
        vdone = 1'b0;
        cmp("pend_timeout", 2'b01, {1'b0, pend});
        rst();
        vmis = 1'b1;
        step(1);
        vmis = 1'b0;
        step(1);
        cmp("mismatch", 2'b11, {mis_l, simplex});
        cmp("mis_sup_run", 2'b00, {1'b0, sup_run});
        rst();
        bus_f = 1'b1;
        step(1);
        bus_f = 1'b0;
        step(1);
        cmp("bus", 2'b11, {bus_l, simplex});
        cmp("bus_sup_run", 2'b00, {1'b0, sup_run});
        rst();
        fat = 2'b01;
        step(1);
        fat = 2'b00;
        cmp("fatal", 2'b01, fat_l);
        cmp("fatal_run", 2'b10, run_l);
        cmp("fatal_halt", 2'b01, halt & offo);
        step(1);
        cmp("active", 2'b10, act);
        rst();
        cflt = 2'b10;
        step(1);
        cflt = 2'b00;
        cmp("cpu_err", 2'b11, {perr, 1'b1} & halt);
        step(1);
        cmp("cpu_err_run", 2'b00, {1'b0, cpu_run});
        rst();
        mflt = 2'b01;
        step(1);
        mflt = 2'b00;
        cmp("mem_err", 2'b11, {merr, 1'b1} & halt);
        step(1);
        cmp("mem_err_run", 2'b00, {1'b0, cpu_run});
        cmp("panel", 2'b11, {&seen[11:6], &seen[5:0]});
        conclude();
    end
endmodule

`default_nettype wire
